//--- lcdc_pkg.sv
package lcdc_pkg;

    // command opcodes, with the selector bit masked out where one exists
    localparam logic [7:0] CMD_COL_DIR      = 8'ha0;
    localparam logic [7:0] CMD_INVERSE      = 8'ha6;
    localparam logic [7:0] CMD_ALL_ON       = 8'ha4;
    localparam logic [7:0] CMD_BIAS         = 8'ha2;
    localparam logic [7:0] CMD_RMW          = 8'he0;
    localparam logic [7:0] CMD_END          = 8'hee;
    localparam logic [7:0] CMD_SOFT_RESET   = 8'he2;
    localparam logic [7:0] CMD_ROW_DIR      = 8'hc0;
    localparam logic [7:0] CMD_POWER        = 8'h28;
    localparam logic [7:0] CMD_RATIO        = 8'h20;
    localparam logic [7:0] CMD_CONTRAST     = 8'h81;
    localparam logic [7:0] CMD_TEST         = 8'hf0;
    localparam logic [7:0] CMD_NOP          = 8'he3;

    // opcode compare masks
    localparam logic [7:0] MASK_BIT0        = 8'hfe;
    localparam logic [7:0] MASK_ROW_DIR     = 8'hf0;
    localparam logic [7:0] MASK_LOW3        = 8'hf8;
    localparam logic [7:0] MASK_LOW4        = 8'hf0;

    // field positions
    localparam int SEL_BIT                  = 0;
    localparam int ROW_DIR_BIT              = 3;
    localparam int PWR_BOOST_BIT            = 2;
    localparam int PWR_REG_BIT              = 1;
    localparam int PWR_FOLLOW_BIT           = 0;

    // reset values, and the column address top value
    localparam logic [7:0] COL_ADDR_RST     = 8'h00;
    localparam logic [7:0] COL_ADDR_MAX     = 8'hff;
    localparam logic [2:0] RATIO_RST        = 3'h0;
    localparam logic [5:0] VOLUME_RST       = 6'h20;
    localparam logic [2:0] POWER_RST        = 3'h0;

    // busy time after a soft reset, in ns, and its cycle count at 20 MHz
    localparam int CLK_PERIOD_NS            = 50;
    localparam int SOFT_RESET_NS            = 200;
    localparam int SOFT_RESET_CYC           = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SOFT_RESET_CNT   = 4'(SOFT_RESET_CYC);

    typedef enum logic [1:0] {ST_IDLE, ST_CONTRAST, ST_BUSY} lcdc_state_t;

    // true when a byte matches opcode under mask
    function automatic logic lcdc_match(input logic [7:0] b, input logic [7:0] op,
                                        input logic [7:0] m);
        return (b & m) == (op & m);
    endfunction

endpackage

//--- lcdc_sync.sv
`timescale 1ns/100ps
module lcdc_sync
    import lcdc_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

//--- lcdc_col_addr.sv
`timescale 1ns/100ps
module lcdc_col_addr
    import lcdc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // controls
    input  wire logic       clear_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_val_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       rmw_enter_i,
    input  wire logic       rmw_end_i,
    // state
    output logic            rmw_o,
    output logic      [7:0] addr_o
);
    logic [7:0] saved_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_o    <= COL_ADDR_RST;
            saved_reg <= COL_ADDR_RST;
            rmw_o     <= 1'b0;
        end else if (ce_i) begin
            if (clear_i) begin
                addr_o <= COL_ADDR_RST;
                rmw_o  <= 1'b0;
            end else if (rmw_end_i && rmw_o) begin
                addr_o <= saved_reg;
                rmw_o  <= 1'b0;
            end else if (rmw_enter_i) begin
                saved_reg <= addr_o;
                rmw_o     <= 1'b1;
            end else if (load_i) begin
                addr_o <= load_val_i;
            end else if ((wr_i || (rd_i && !rmw_o)) && addr_o != COL_ADDR_MAX) begin
                addr_o <= addr_o + 8'h01;
            end
        end
    end
endmodule

//--- lcdc_decoder.sv
`timescale 1ns/100ps
module lcdc_decoder
    import lcdc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // host read/write port, asynchronous to clk_i
    input  wire logic       wr_strobe_i,
    input  wire logic       command_data_select_i,
    input  wire logic [7:0] data_i,
    input  wire logic       rd_strobe_i,
    // external column load from the address-set logic
    input  wire logic       col_load_i,
    input  wire logic [7:0] col_load_val_i,
    // display settings
    output logic            col_reverse_o,
    output logic            inverse_o,
    output logic            all_on_o,
    output logic            pixel_invert_o,
    output logic            pixel_force_o,
    output logic            bias_seventh_o,
    output logic            bias_active_o,
    output logic            row_reverse_o,
    // power settings
    output logic            booster_on_o,
    output logic            regulator_on_o,
    output logic            follower_on_o,
    output logic      [2:0] ratio_o,
    output logic      [5:0] volume_o,
    // address and modes
    output logic      [7:0] col_addr_o,
    output logic            rmw_o,
    output logic            test_mode_o,
    output logic            soft_reset_o,
    output logic            busy_o
);
    logic [2:0]  strobe_s;
    logic [7:0]  data_s;
    logic        wr_s;
    logic        wr_d_reg;
    logic        rd_s;
    logic        rd_d_reg;
    logic        a0_s;
    logic        wr_pulse;
    logic        rd_pulse;
    logic        cmd_pulse;
    logic        data_wr_pulse;
    logic        data_rd_pulse;
    lcdc_state_t state_reg;
    lcdc_state_t state_next;
    logic [3:0]  busy_cnt_reg;
    logic        soft_clr;
    logic        col_rmw;
    logic [7:0]  col_addr;
    logic [2:0]  power_reg;
    logic        idle_cmd;
    logic        contrast_cmd;
    logic        rmw_enter;
    logic        rmw_end;

    // pins pass two flops before use
    lcdc_sync #(.W(3)) u_sync_ctl (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({wr_strobe_i, rd_strobe_i, command_data_select_i}),
        .q_o   (strobe_s)
    );

    // same depth as the strobes keeps byte and strobe aligned
    lcdc_sync #(.W(8)) u_sync_data (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (data_i),
        .q_o   (data_s)
    );

    assign wr_s = strobe_s[2];
    assign rd_s = strobe_s[1];
    assign a0_s = strobe_s[0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_d_reg <= 1'b0;
            rd_d_reg <= 1'b0;
        end else if (ce_i) begin
            wr_d_reg <= wr_s;
            rd_d_reg <= rd_s;
        end
    end

    // act on the rising edge of each strobe
    assign wr_pulse      = wr_s && !wr_d_reg;
    assign rd_pulse      = rd_s && !rd_d_reg;
    assign cmd_pulse     = wr_pulse && !a0_s && state_reg != ST_BUSY;
    assign data_wr_pulse = wr_pulse && a0_s;
    assign data_rd_pulse = rd_pulse && a0_s;

    // commands split by sequencer state
    assign idle_cmd     = cmd_pulse && state_reg == ST_IDLE;
    assign contrast_cmd = cmd_pulse && state_reg == ST_CONTRAST;

    // soft reset opcode, no RAM clear here
    assign soft_clr = idle_cmd && data_s == CMD_SOFT_RESET;

    assign rmw_enter = idle_cmd && data_s == CMD_RMW;
    assign rmw_end   = idle_cmd && data_s == CMD_END;

    // sequencing: idle, contrast data wait, busy after soft reset
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_pulse && data_s == CMD_CONTRAST) begin
                    state_next = ST_CONTRAST;
                end else if (soft_clr) begin
                    state_next = ST_BUSY;
                end
            end
            ST_CONTRAST: begin
                if (cmd_pulse) begin
                    state_next = ST_IDLE;
                end
            end
            ST_BUSY: begin
                // commands are dropped until the count runs out
                if (busy_cnt_reg == 4'h1) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt_reg <= 4'h0;
        end else if (ce_i) begin
            if (soft_clr) begin
                busy_cnt_reg <= SOFT_RESET_CNT;
            end else if (busy_cnt_reg != 4'h0) begin
                busy_cnt_reg <= busy_cnt_reg - 4'h1;
            end
        end
    end

    lcdc_col_addr u_col (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clear_i     (soft_clr),
        .load_i      (col_load_i),
        .load_val_i  (col_load_val_i),
        .wr_i        (data_wr_pulse),
        .rd_i        (data_rd_pulse),
        .rmw_enter_i (rmw_enter),
        .rmw_end_i   (rmw_end),
        .rmw_o       (col_rmw),
        .addr_o      (col_addr)
    );

    // display settings, not touched by soft reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            col_reverse_o  <= 1'b0;
            inverse_o      <= 1'b0;
            all_on_o       <= 1'b0;
            bias_seventh_o <= 1'b0;
        end else if (ce_i && idle_cmd) begin
            if (lcdc_match(data_s, CMD_COL_DIR, MASK_BIT0)) begin
                col_reverse_o <= data_s[SEL_BIT];
            end
            if (lcdc_match(data_s, CMD_INVERSE, MASK_BIT0)) begin
                inverse_o <= data_s[SEL_BIT];
            end
            if (lcdc_match(data_s, CMD_ALL_ON, MASK_BIT0)) begin
                all_on_o <= data_s[SEL_BIT];
            end
            if (lcdc_match(data_s, CMD_BIAS, MASK_BIT0)) begin
                bias_seventh_o <= data_s[SEL_BIT];
            end
        end
    end

    // power stages, kept across soft reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_reg <= POWER_RST;
        end else if (ce_i && idle_cmd) begin
            if (lcdc_match(data_s, CMD_POWER, MASK_LOW3)) begin
                power_reg <= data_s[2:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            row_reverse_o <= 1'b0;
            ratio_o       <= RATIO_RST;
            volume_o      <= VOLUME_RST;
            test_mode_o   <= 1'b0;
        end else if (ce_i) begin
            if (soft_clr) begin
                row_reverse_o <= 1'b0;
                ratio_o       <= RATIO_RST;
                volume_o      <= VOLUME_RST;
                test_mode_o   <= 1'b0;
            end else if (contrast_cmd) begin
                volume_o <= data_s[5:0];
            end else if (idle_cmd) begin
                if (lcdc_match(data_s, CMD_ROW_DIR, MASK_ROW_DIR)) begin
                    row_reverse_o <= data_s[ROW_DIR_BIT];
                end
                if (lcdc_match(data_s, CMD_RATIO, MASK_LOW3)) begin
                    ratio_o <= data_s[2:0];
                end
                // test mode: any Fx enters, nop leaves
                if (lcdc_match(data_s, CMD_TEST, MASK_LOW4)) begin
                    test_mode_o <= 1'b1;
                end else if (data_s == CMD_NOP) begin
                    test_mode_o <= 1'b0;
                end
            end
        end
    end

    // registered outputs derived from the held settings, the column state and the soft reset count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pixel_force_o  <= 1'b0;
            pixel_invert_o <= 1'b0;
            bias_active_o  <= 1'b0;
            booster_on_o   <= 1'b0;
            regulator_on_o <= 1'b0;
            follower_on_o  <= 1'b0;
            col_addr_o     <= COL_ADDR_RST;
            rmw_o          <= 1'b0;
            soft_reset_o   <= 1'b0;
            busy_o         <= 1'b0;
        end else if (ce_i) begin
            pixel_force_o  <= all_on_o;
            pixel_invert_o <= inverse_o && !all_on_o;
            bias_active_o  <= power_reg[PWR_FOLLOW_BIT];
            booster_on_o   <= power_reg[PWR_BOOST_BIT];
            regulator_on_o <= power_reg[PWR_REG_BIT];
            follower_on_o  <= power_reg[PWR_FOLLOW_BIT];
            // column and rmw lag the inner copy by a clock
            col_addr_o     <= col_addr;
            rmw_o          <= col_rmw;
            soft_reset_o   <= soft_clr || busy_cnt_reg != 4'h0;
            busy_o         <= soft_clr || busy_cnt_reg > 4'h1;
        end
    end
endmodule

//--- lcdc_decoder_chk.sv
`timescale 1ns/100ps
module lcdc_decoder_chk
    import lcdc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // host side
    input  wire logic       wr_strobe_i,
    input  wire logic       col_load_i,
    // settings
    input  wire logic       col_reverse_o,
    input  wire logic       inverse_o,
    input  wire logic       all_on_o,
    input  wire logic       pixel_invert_o,
    input  wire logic       pixel_force_o,
    input  wire logic       bias_seventh_o,
    input  wire logic       bias_active_o,
    input  wire logic       row_reverse_o,
    input  wire logic       booster_on_o,
    input  wire logic       regulator_on_o,
    input  wire logic       follower_on_o,
    input  wire logic [2:0] ratio_o,
    input  wire logic [5:0] volume_o,
    // address and modes
    input  wire logic [7:0] col_addr_o,
    input  wire logic       rmw_o,
    input  wire logic       test_mode_o,
    input  wire logic       soft_reset_o,
    input  wire logic       busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_force;
        pixel_force_o == $past(all_on_o);
    endproperty
    a_force: assert property (p_force) else $error("pixel force not following all-on");

    property p_invert;
        pixel_invert_o == $past(inverse_o && !all_on_o);
    endproperty
    a_invert: assert property (p_invert) else $error("pixel invert not masked by all-on");

    property p_bias_act;
        bias_active_o == follower_on_o;
    endproperty
    a_bias_act: assert property (p_bias_act) else $error("bias active not tied to follower");

    property p_sat;
        (col_addr_o == COL_ADDR_MAX && !rmw_o && !col_load_i && !$past(col_load_i) && !soft_reset_o)
            |=> (col_addr_o == COL_ADDR_MAX || soft_reset_o);
    endproperty
    a_sat: assert property (p_sat) else $error("column address left its top value");

    property p_soft_pulse;
        $rose(soft_reset_o) |-> soft_reset_o [*5] ##1 !soft_reset_o;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse length wrong");

    property p_busy;
        $rose(busy_o) |-> busy_o [*4] ##1 !busy_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");

    property p_soft_vals;
        $rose(soft_reset_o) |-> ##[1:4] (ratio_o == RATIO_RST && volume_o == VOLUME_RST
            && !row_reverse_o && !rmw_o && !test_mode_o && col_addr_o == COL_ADDR_RST);
    endproperty
    a_soft_vals: assert property (p_soft_vals) else $error("soft reset values wrong");

    property p_hold;
        (!wr_strobe_i && !soft_reset_o) [*7] |-> $stable({col_reverse_o, inverse_o, all_on_o,
            bias_seventh_o, row_reverse_o, booster_on_o, regulator_on_o, follower_on_o,
            ratio_o, volume_o, test_mode_o});
    endproperty
    a_hold: assert property (p_hold) else $error("setting changed with no command");

    property p_rmw_hold;
        (rmw_o && !wr_strobe_i && !col_load_i) [*7] |=> $stable(col_addr_o);
    endproperty
    a_rmw_hold: assert property (p_rmw_hold) else $error("column moved in rmw without write");

    c_rmw: cover property ($rose(rmw_o));
    c_sat: cover property (col_addr_o == COL_ADDR_MAX);
    c_force: cover property (pixel_force_o && inverse_o);
    c_soft: cover property ($rose(soft_reset_o));
endmodule

bind lcdc_decoder lcdc_decoder_chk i_lcdc_decoder_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wr_strobe_i(wr_strobe_i), .col_load_i(col_load_i),
    .col_reverse_o(col_reverse_o), .inverse_o(inverse_o), .all_on_o(all_on_o),
    .pixel_invert_o(pixel_invert_o), .pixel_force_o(pixel_force_o),
    .bias_seventh_o(bias_seventh_o), .bias_active_o(bias_active_o),
    .row_reverse_o(row_reverse_o), .booster_on_o(booster_on_o),
    .regulator_on_o(regulator_on_o), .follower_on_o(follower_on_o), .ratio_o(ratio_o),
    .volume_o(volume_o), .col_addr_o(col_addr_o), .rmw_o(rmw_o),
    .test_mode_o(test_mode_o), .soft_reset_o(soft_reset_o), .busy_o(busy_o));

//--- lcdc_host_model.sv
`timescale 1ns/100ps
module lcdc_host_model (
    // clock
    input  wire logic       clk_i,
    // host port
    output logic            wr_o,
    output logic            rd_o,
    output logic            cds_o,
    output logic      [7:0] data_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        cds_o = 1'b0;
        data_o = 8'h00;
    end

    // power-up via hardware reset by bench
    task automatic xfer(input logic rd, input logic cds, input logic [7:0] b);
        @(posedge clk_i);
        cds_o <= cds;
        data_o <= b;
        repeat (3) @(posedge clk_i);
        if (rd)
            rd_o <= 1'b1;
        else
            wr_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        // released bus shows inverted value
        cds_o <= ~cds;
        data_o <= ~b;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

//--- lcd_display_command_decoder_tb.sv
`timescale 1ns/100ps
module lcd_display_command_decoder_tb;
    import lcdc_pkg::*;
    localparam logic [7:0] OPS [12] = '{8'ha0, 8'ha6, 8'ha4, 8'ha2, 8'he0, 8'hee, 8'he2,
                                        8'hc0, 8'h28, 8'h20, 8'h81, 8'he3};
    localparam logic [7:0] LOWM [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
                                         8'h0f, 8'h07, 8'h07, 8'h00, 8'h00};
    localparam logic [9:0] CORNER [26] = '{10'h3ff, 10'h100, 10'h100, 10'h310, 10'h0e0,
        10'h200, 10'h100, 10'h200, 10'h100, 10'h0ee, 10'h0a7, 10'h0a5, 10'h0a4, 10'h081,
        10'h0e2, 10'h0c8, 10'h025, 10'h02f, 10'h0a3, 10'h0a1, 10'h0f7, 10'h0e2, 10'h0f5,
        10'h0e3, 10'h081, 10'h020};
    logic       clk_i;
    logic       rst_i;
    logic       ce_i;
    logic       col_load_i;
    logic [7:0] col_load_val_i;
    wire logic  wr_s;
    wire logic  rd_s;
    wire logic  cds_s;
    wire logic [7:0]  bus_s;
    wire logic [29:0] got;
    int         bad_count;
    int         checked;
    logic       e_cdir, e_inv, e_all, e_bias, e_row, e_rmw, e_test, e_cmode;
    logic [2:0] e_pwr, e_ratio;
    logic [5:0] e_vol;
    logic [7:0] e_col, e_save, v;
    logic [1:0] k;

    lcdc_host_model i_lcdc_host_model (.clk_i(clk_i), .wr_o(wr_s), .rd_o(rd_s),
        .cds_o(cds_s), .data_o(bus_s));

    lcdc_decoder i_lcdc_decoder (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wr_strobe_i(wr_s), .command_data_select_i(cds_s), .data_i(bus_s), .rd_strobe_i(rd_s),
        .col_load_i(col_load_i), .col_load_val_i(col_load_val_i),
        .col_reverse_o(got[29]), .inverse_o(got[28]), .all_on_o(got[27]),
        .pixel_invert_o(got[26]), .pixel_force_o(got[25]), .bias_seventh_o(got[24]),
        .bias_active_o(got[23]), .row_reverse_o(got[22]), .booster_on_o(got[21]),
        .regulator_on_o(got[20]), .follower_on_o(got[19]), .ratio_o(got[18:16]),
        .volume_o(got[15:10]), .col_addr_o(got[9:2]), .rmw_o(got[1]), .test_mode_o(got[0]),
        .soft_reset_o(), .busy_o());

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [29:0] expv();
        return {e_cdir, e_inv, e_all, e_inv & ~e_all, e_all, e_bias, e_pwr[0], e_row,
                e_pwr, e_ratio, e_vol, e_col, e_rmw, e_test};
    endfunction

    task automatic model_reset();
        {e_cdir, e_inv, e_all, e_bias, e_row, e_rmw, e_test, e_cmode} = 8'h00;
        {e_pwr, e_ratio, e_col, e_save} = 22'h0;
        e_vol = VOLUME_RST;
    endtask

    task automatic model_cmd(input logic [7:0] b);
        if (e_cmode) begin
            e_vol = b[5:0];
            e_cmode = 1'b0;
        end else if (b[7:1] == 7'h50) e_cdir = b[0];
        else if (b[7:1] == 7'h53) e_inv = b[0];
        else if (b[7:1] == 7'h52) e_all = b[0];
        else if (b[7:1] == 7'h51) e_bias = b[0];
        else if (b == 8'he0) begin
            e_rmw = 1'b1;
            e_save = e_col;
        end else if (b == 8'hee && e_rmw) begin
            e_rmw = 1'b0;
            e_col = e_save;
        end else if (b == 8'he2) begin
            {e_row, e_test, e_rmw, e_ratio, e_col} = 14'h0;
            e_vol = VOLUME_RST;
        end else if (b[7:4] == 4'hc) e_row = b[3];
        else if (b[7:3] == 5'h05) e_pwr = b[2:0];
        else if (b[7:3] == 5'h04) e_ratio = b[2:0];
        else if (b == 8'h81) e_cmode = 1'b1;
        else if (b[7:4] == 4'hf) e_test = 1'b1;
        else if (b == 8'he3) e_test = 1'b0;
    endtask

    task automatic chk(input logic [29:0] e);
        checked++;
        if (got !== e) begin
            bad_count++;
            $display("BAD state exp %h got %h", e, got);
        end
    endtask

    // kind 0 command, 1 data write, 2 data read, 3 column load
    task automatic do_op(input logic [1:0] kind, input logic [7:0] b);
        if (kind == 2'd3) begin
            @(posedge clk_i);
            col_load_i <= 1'b1;
            col_load_val_i <= b;
            @(posedge clk_i);
            col_load_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            e_col = b;
        end else begin
            i_lcdc_host_model.xfer(kind[1], kind != 2'd0, b);
            if (kind == 2'd0) model_cmd(b);
            else if ((kind == 2'd1 || !e_rmw) && e_col != COL_ADDR_MAX) e_col = e_col + 8'h01;
        end
        // settings, derived outputs, column and modes
        chk(expv());
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        bad_count++;
        wrap_up();
    end

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        col_load_i = 1'b0;
        col_load_val_i = 8'h00;
        bad_count = 0;
        checked = 0;
        void'($urandom(32'h28d2));
        model_reset();
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(expv());
        // last corner pair writes the recommended volume
        foreach (CORNER[n]) do_op(CORNER[n][9:8], CORNER[n][7:0]);
        for (int n = 0; n < 150; n++) begin
            k = 2'($urandom_range(3, 0));
            // no column load while in rmw
            if (k == 2'd3 && e_rmw) k = 2'd1;
            v = 8'($urandom);
            if (k == 2'd0) v = OPS[n % 12] | (v & LOWM[n % 12]);
            if (v == 8'he0 && e_rmw && k == 2'd0) v = 8'he3;
            do_op(k, v);
            if (k == 2'd0 && v == 8'h81) do_op(2'd0, 8'($urandom));
        end
        // frozen clock enable swallows a whole command
        @(posedge clk_i);
        ce_i <= 1'b0;
        i_lcdc_host_model.xfer(1'b0, 1'b0, {7'h53, ~e_inv});
        ce_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(expv());
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        model_reset();
        repeat (2) @(posedge clk_i);
        chk(expv());
        wrap_up();
    end
endmodule
